// ---- hdl/apats_consts.svh ----
// register map, field layout, reset values and scaling constants of the supervisor
`ifndef APATS_CONSTS_SVH
`define APATS_CONSTS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define APATS_OFS_SCALE 8'h00
`define APATS_OFS_ALM_LO 8'h04
`define APATS_OFS_ALM_HI 8'h08
`define APATS_OFS_TRIP_LO 8'h0c
`define APATS_OFS_TRIP_HI 8'h10
`define APATS_OFS_ALM_DLY 8'h14
`define APATS_OFS_TRIP_DLY 8'h18
`define APATS_OFS_GRACE 8'h1c
`define APATS_OFS_STATUS 8'h20
`define APATS_OFS_IRQ_STAT 8'h24
`define APATS_OFS_IRQ_MASK 8'h28
`define APATS_OFS_CTRL 8'h2c
`define APATS_NUM_CFG 8
// ----------------------------------------------------------------
// reset values and writable masks of the setting registers
// ----------------------------------------------------------------
`define APATS_RST_SCALE 32'h03e8_0000
`define APATS_RST_LEVEL 32'h0000_0000
`define APATS_RST_DLY 32'h0005_0005
`define APATS_RST_GRACE 32'h0000_0505
`define APATS_MASK_SCALE 32'hffff_ffff
`define APATS_MASK_LEVEL 32'h0000_ffff
`define APATS_MASK_DLY 32'h03ff_03ff
`define APATS_MASK_GRACE 32'h0000_ffff
// ----------------------------------------------------------------
// field codes and loop current scaling
// ----------------------------------------------------------------
`define APATS_LEVEL_OFF 16'h0000
`define APATS_DLY_OFF 10'h000
`define APATS_GRACE_OFF 8'hff
`define APATS_CUR_MIN_UA 15'h0fa0
`define APATS_CUR_MAX_UA 15'h4e20
`define APATS_CUR_SPAN_UA 31'h0000_3e80
`define APATS_RESP_OKAY 2'h0
`define APATS_RESP_SLVERR 2'h2
`endif

// ---- hdl/apats_pkg.sv ----
// types shared by the analog alarm and trip supervisor
package apats_pkg;
    typedef logic [15:0] level_t;
    typedef logic [14:0] current_t;
    typedef enum logic [1:0] {
        GRACE_IDLE = 2'b01,
        GRACE_WAIT = 2'b10
    } grace_state_e;
endpackage : apats_pkg

// ---- hdl/analog_process_alarm_trip_supervisor.sv ----
// analog process input supervisor: scaling, alarms, trips, start grace, axi4-lite registers
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "apats_consts.svh"

module analog_process_alarm_trip_supervisor #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire apats_pkg::current_t loop_current_ua_in,
    input wire logic loop_valid_in,
    input wire logic tick_1s_in,
    input wire logic motor_start_in,
    input wire logic motor_running_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output apats_pkg::level_t scaled_value_out,
    output logic alarm_low_out,
    output logic alarm_high_out,
    output logic trip_low_out,
    output logic trip_high_out,
    output logic irq_out
);
    import apats_pkg::*;

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // byte-lane merge of a bus write into a register
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int k = 0; k < 4; k++) begin
            if (strb[k]) begin
                res[8*k +: 8] = new_v[8*k +: 8];
            end
        end
        return res;
    endfunction : merge

    // writable bits of each setting register
    function automatic logic [31:0] cfg_mask(input int idx);
        logic [31:0] m;
        m = `APATS_MASK_LEVEL;
        if (idx == 0) begin
            m = `APATS_MASK_SCALE;
        end else if (idx == 5 || idx == 6) begin
            m = `APATS_MASK_DLY;
        end else if (idx == 7) begin
            m = `APATS_MASK_GRACE;
        end
        return m;
    endfunction : cfg_mask

    function automatic logic [31:0] cfg_reset(input int idx);
        logic [31:0] v;
        v = `APATS_RST_LEVEL;
        if (idx == 0) begin
            v = `APATS_RST_SCALE;
        end else if (idx == 5 || idx == 6) begin
            v = `APATS_RST_DLY;
        end else if (idx == 7) begin
            v = `APATS_RST_GRACE;
        end
        return v;
    endfunction : cfg_reset

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [31:0] cfg_r [`APATS_NUM_CFG];
    logic [3:0] irq_stat_r;
    logic [3:0] irq_mask_r;
    level_t scaled_r;
    logic [9:0] cnt_r [4];
    logic [3:0] qual_d_r;
    logic [1:0] trip_r;
    grace_state_e gstate_r [2];
    logic [6:0] gcnt_r [2];
    logic aw_held_r, w_held_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    level_t level_w [4];
    logic [9:0] delay_w [4];
    logic [7:0] grace_w [2];
    logic [3:0] raw_w, cond_w, qual_w;
    logic [1:0] imm_w, grace_off_w, trip_set_w;
    logic [3:0] irq_ev_w;

    // ----------------------------------------------------------------
    // scaling of the loop current
    // ----------------------------------------------------------------
    // out-of-range currents clamp to the ends; a reversed scale reads as min below 20 mA and as max from 20 mA up
    wire level_t scale_min_w = cfg_r[0][15:0];
    wire level_t scale_max_w = cfg_r[0][31:16];
    wire level_t span_w = (scale_max_w > scale_min_w) ? 16'(scale_max_w - scale_min_w) : 16'h0000;
    wire logic [14:0] cur_off_w = 15'(loop_current_ua_in - `APATS_CUR_MIN_UA);
    wire logic [30:0] prod_w = 31'(cur_off_w) * 31'(span_w);
    wire level_t quot_w = 16'(prod_w / `APATS_CUR_SPAN_UA);
    wire level_t scaled_nxt = (loop_current_ua_in <= `APATS_CUR_MIN_UA) ? scale_min_w :
                              (loop_current_ua_in >= `APATS_CUR_MAX_UA) ? scale_max_w :
                              16'(scale_min_w + quot_w);

    // converter result latched on its strobe
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            scaled_r <= 16'h0000;
        end else if (loop_valid_in) begin
            scaled_r <= scaled_nxt;
        end
    end

    // ----------------------------------------------------------------
    // comparisons and persistence timers
    // ----------------------------------------------------------------
    // index 0 alarm low, 1 alarm high, 2 trip low, 3 trip high
    assign level_w[0] = cfg_r[1][15:0];
    assign level_w[1] = cfg_r[2][15:0];
    assign level_w[2] = cfg_r[3][15:0];
    assign level_w[3] = cfg_r[4][15:0];
    assign delay_w[0] = cfg_r[5][9:0];
    assign delay_w[1] = cfg_r[5][25:16];
    assign delay_w[2] = cfg_r[6][9:0];
    assign delay_w[3] = cfg_r[6][25:16];
    assign grace_w[0] = cfg_r[7][7:0];
    assign grace_w[1] = cfg_r[7][15:8];
    assign grace_off_w[0] = (grace_w[0] == `APATS_GRACE_OFF);
    assign grace_off_w[1] = (grace_w[1] == `APATS_GRACE_OFF);

    // level zero means the comparison is switched off
    assign raw_w[0] = (level_w[0] != `APATS_LEVEL_OFF) && (scaled_r < level_w[0]);
    assign raw_w[1] = (level_w[1] != `APATS_LEVEL_OFF) && (scaled_r > level_w[1]);
    assign raw_w[2] = (level_w[2] != `APATS_LEVEL_OFF) && (scaled_r < level_w[2]);
    assign raw_w[3] = (level_w[3] != `APATS_LEVEL_OFF) && (scaled_r > level_w[3]);

    // trips with a grace setting only count while running and past the window
    assign cond_w[1:0] = raw_w[1:0];
    assign cond_w[2] = raw_w[2] && (grace_off_w[0] ||
                       (motor_running_in && gstate_r[0] == GRACE_IDLE));
    assign cond_w[3] = raw_w[3] && (grace_off_w[1] ||
                       (motor_running_in && gstate_r[1] == GRACE_IDLE));

    // a delay of zero is off and never qualifies
    generate
        for (genvar i = 0; i < 4; i++) begin : g_persist
            assign qual_w[i] = cond_w[i] && (delay_w[i] != `APATS_DLY_OFF) &&
                               (cnt_r[i] >= delay_w[i]);
            always_ff @(posedge clk_sys_in) begin
                if (reset_in || !cond_w[i]) begin
                    cnt_r[i] <= 10'h000;
                end else if (tick_1s_in && cnt_r[i] < delay_w[i]) begin
                    cnt_r[i] <= 10'(cnt_r[i] + 10'h001);
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // post-start grace window
    // ----------------------------------------------------------------
    // zero grace: unhealthy at start trips at once; expiry while unhealthy trips too
    generate
        for (genvar g = 0; g < 2; g++) begin : g_grace
            wire logic expire_w = (gstate_r[g] == GRACE_WAIT) && tick_1s_in &&
                                  (7'(gcnt_r[g] + 7'h01) >= 7'(grace_w[g]));
            assign imm_w[g] = !grace_off_w[g] && raw_w[2+g] &&
                              ((motor_start_in && grace_w[g] == 8'h00) || expire_w);
            always_ff @(posedge clk_sys_in) begin
                if (reset_in) begin
                    gstate_r[g] <= GRACE_IDLE;
                    gcnt_r[g] <= 7'h00;
                end else begin
                    unique case (gstate_r[g])
                        GRACE_IDLE: begin
                            gcnt_r[g] <= 7'h00;
                            if (motor_start_in && !grace_off_w[g] && grace_w[g] != 8'h00) begin
                                gstate_r[g] <= GRACE_WAIT;
                            end
                        end
                        GRACE_WAIT: begin
                            if (!raw_w[2+g] || !motor_running_in || expire_w) begin
                                gstate_r[g] <= GRACE_IDLE;
                            end else if (tick_1s_in) begin
                                gcnt_r[g] <= 7'(gcnt_r[g] + 7'h01);
                            end
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // outputs, trip latches and interrupt status
    // ----------------------------------------------------------------
    wire logic wr_go_w = aw_held_r && w_held_r && !bvalid_r;
    wire logic [5:0] wr_idx_w = awaddr_r[7:2];
    wire logic ctrl_wr_w = wr_go_w && awaddr_r[7:0] == `APATS_OFS_CTRL && wstrb_r[0];
    wire logic trip_clr_w = ctrl_wr_w && wdata_r[0];
    wire logic stat_wr_w = wr_go_w && awaddr_r[7:0] == `APATS_OFS_IRQ_STAT && wstrb_r[0];
    wire logic mask_wr_w = wr_go_w && awaddr_r[7:0] == `APATS_OFS_IRQ_MASK && wstrb_r[0];
    assign trip_set_w = {qual_w[3] || imm_w[1], qual_w[2] || imm_w[0]};
    // rising edge of each qualified state; trips count once per latch
    assign irq_ev_w = {trip_set_w & ~trip_r, qual_w[1:0] & ~qual_d_r[1:0]};

    // trips latch until software clears them; a new trip wins over the clear
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            trip_r <= 2'b00;
            qual_d_r <= 4'h0;
            irq_stat_r <= 4'h0;
            irq_mask_r <= 4'h0;
            irq_out <= 1'b0;
        end else begin
            trip_r <= trip_set_w | (trip_r & {2{!trip_clr_w}});
            qual_d_r <= qual_w;
            irq_stat_r <= irq_ev_w | (irq_stat_r & ~(stat_wr_w ? wdata_r[3:0] : 4'h0));
            irq_mask_r <= mask_wr_w ? wdata_r[3:0] : irq_mask_r;
            irq_out <= |(irq_stat_r & irq_mask_r);
        end
    end
    assign scaled_value_out = scaled_r;
    assign alarm_low_out = qual_d_r[0];
    assign alarm_high_out = qual_d_r[1];
    assign trip_low_out = trip_r[0];
    assign trip_high_out = trip_r[1];

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    // address and data are held separately so either may arrive first
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= `APATS_RESP_OKAY;
            awaddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                aw_held_r <= 1'b1;
                awready_r <= 1'b0;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_r) begin
                w_held_r <= 1'b1;
                wready_r <= 1'b0;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go_w) begin
                bvalid_r <= 1'b1;
                bresp_r <= (awaddr_r[7:0] > `APATS_OFS_CTRL || awaddr_r[7:0] == `APATS_OFS_STATUS) ?
                           `APATS_RESP_SLVERR : `APATS_RESP_OKAY;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // setting registers take the byte lanes that are written
    generate
        for (genvar c = 0; c < `APATS_NUM_CFG; c++) begin : g_cfg
            always_ff @(posedge clk_sys_in) begin
                if (reset_in) begin
                    cfg_r[c] <= cfg_reset(c);
                end else if (wr_go_w && wr_idx_w == 6'(c)) begin
                    // unwritable bits keep their value, writable bits take the merged word
                    cfg_r[c] <= (cfg_r[c] & ~cfg_mask(c)) |
                                (merge(cfg_r[c], wdata_r, wstrb_r) & cfg_mask(c));
                end
            end
        end
    endgenerate

    // read mux: control is write-only, unmapped answers slverr
    wire logic [7:0] ra_w = s_axi_araddr[7:0];
    wire logic [31:0] stat_rd_w = {scaled_r, 10'h000, gstate_r[1] == GRACE_WAIT,
                                   gstate_r[0] == GRACE_WAIT, trip_r, qual_d_r[1:0]};
    wire logic [31:0] rd_mux_w = (ra_w < `APATS_OFS_STATUS) ? cfg_r[ra_w[4:2]] :
                                 (ra_w == `APATS_OFS_STATUS) ? stat_rd_w :
                                 (ra_w == `APATS_OFS_IRQ_STAT) ? {28'h0, irq_stat_r} :
                                 (ra_w == `APATS_OFS_IRQ_MASK) ? {28'h0, irq_mask_r} : 32'h0;
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `APATS_RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux_w;
            rresp_r <= (ra_w > `APATS_OFS_CTRL) ? `APATS_RESP_SLVERR : `APATS_RESP_OKAY;
        end else if (rvalid_r && s_axi_rready) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    property p_scale_low_clamp;
        loop_valid_in && loop_current_ua_in <= `APATS_CUR_MIN_UA |=> scaled_r == $past(scale_min_w);
    endproperty
    a_scale_low_clamp: assert property (p_scale_low_clamp) else $error("min clamp wrong");
    property p_alm_lo_cond;
        qual_w[0] |-> level_w[0] != 16'h0 && scaled_r < level_w[0];
    endproperty
    a_alm_lo_cond: assert property (p_alm_lo_cond) else $error("low alarm without cause");
    property p_alm_lo_delay;
        $rose(qual_w[0]) |-> delay_w[0] != 10'h0 && cnt_r[0] == delay_w[0];
    endproperty
    a_alm_lo_delay: assert property (p_alm_lo_delay) else $error("low alarm early");
    property p_alm_hi_out;
        qual_w[1] && raw_w[1] |=> alarm_high_out && $past(scaled_r) > $past(level_w[1]);
    endproperty
    a_alm_hi_out: assert property (p_alm_hi_out) else $error("high alarm missing");
    property p_trip_hi_cond;
        qual_w[3] |-> scaled_r > level_w[3] && cnt_r[3] >= delay_w[3];
    endproperty
    a_trip_hi_cond: assert property (p_trip_hi_cond) else $error("high trip early");
    property p_restart;
        !cond_w[2] |=> cnt_r[2] == 10'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("timer not restarted");
    property p_grace0_lo;
        motor_start_in && grace_w[0] == 8'h00 && raw_w[2] |=> trip_low_out;
    endproperty
    a_grace0_lo: assert property (p_grace0_lo) else $error("zero grace no trip");
    property p_grace0_hi;
        motor_start_in && grace_w[1] == 8'h00 && raw_w[3] |=> trip_high_out;
    endproperty
    a_grace0_hi: assert property (p_grace0_hi) else $error("zero grace no trip");
    property p_grace_off_lo;
        grace_off_w[0] |-> cond_w[2] == raw_w[2] && gstate_r[0] == GRACE_IDLE;
    endproperty
    a_grace_off_lo: assert property (p_grace_off_lo) else $error("low trip masked");
    property p_grace_off_hi;
        grace_off_w[1] |-> cond_w[3] == raw_w[3];
    endproperty
    a_grace_off_hi: assert property (p_grace_off_hi) else $error("high trip masked");
    c_alarm_low: cover property ($rose(alarm_low_out));
    c_trip_after_grace: cover property (gstate_r[1] == GRACE_WAIT ##1 $rose(trip_high_out));
    c_irq: cover property ($rose(irq_out));
endmodule : analog_process_alarm_trip_supervisor

// ---- tb/front_end_model.sv ----
// model of the converter front end and the motor starter
`timescale 1ns/1ps
module front_end_model #(
    parameter int TICK_DIV = 16
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire apats_pkg::current_t level_ua_in,
    input wire logic start_req_in,
    input wire logic stop_req_in,
    output apats_pkg::current_t loop_current_ua_out = 15'h0fa0,
    output logic loop_valid_out = 1'b0,
    output logic tick_1s_out = 1'b0,
    output logic motor_start_out = 1'b0,
    output logic motor_running_out = 1'b0
);
    import apats_pkg::*;
    logic [7:0] div_r = 8'h00;
    // a second is shortened to TICK_DIV cycles so that delays stay cheap
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            div_r <= 8'h00;
            tick_1s_out <= 1'b0;
            loop_valid_out <= 1'b0;
            motor_start_out <= 1'b0;
            motor_running_out <= 1'b0;
        end else begin
            div_r <= (div_r == 8'(TICK_DIV - 1)) ? 8'h00 : div_r + 8'h01;
            tick_1s_out <= div_r == 8'(TICK_DIV - 1);
            loop_valid_out <= div_r[1:0] == 2'h0;
            loop_current_ua_out <= level_ua_in;
            motor_start_out <= start_req_in & ~motor_running_out;
            motor_running_out <= start_req_in | (motor_running_out & ~stop_req_in);
        end
    end
endmodule : front_end_model

// ---- tb/analog_process_alarm_trip_supervisor_bench.sv ----
// self-checking bench of the analog alarm and trip supervisor
`timescale 1ns/1ps
`include "apats_consts.svh"
`define chk(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module analog_process_alarm_trip_supervisor_bench;
    import apats_pkg::*;
    typedef struct {current_t ua; level_t sv;} row_s;
    logic clk_sys_in = 1'b0, reset_in = 1'b1, start_req = 1'b0, stop_req = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, loop_valid_in, tick_1s_in, motor_start_in, motor_running_in;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    current_t level_ua = 15'h2ee0, loop_current_ua_in;
    level_t scaled_value_out;
    logic alarm_low_out, alarm_high_out, trip_low_out, trip_high_out, irq_out;
    int miscompares = 0, checked = 0, cyc = 0;
    // 3 mA and 21 mA sit outside the loop span and must clamp
    row_s rows[5] = '{'{15'h0bb8, 16'h0000}, '{15'h0fa0, 16'h0000},
        '{15'h2ee0, 16'h01f4}, '{15'h4e20, 16'h03e8}, '{15'h5208, 16'h03e8}};
    front_end_model u_front_end_model (.clk_sys_in, .reset_in, .level_ua_in(level_ua),
        .start_req_in(start_req), .stop_req_in(stop_req),
        .loop_current_ua_out(loop_current_ua_in), .loop_valid_out(loop_valid_in),
        .tick_1s_out(tick_1s_in), .motor_start_out(motor_start_in),
        .motor_running_out(motor_running_in));
    analog_process_alarm_trip_supervisor u_analog_process_alarm_trip_supervisor (
        .clk_sys_in, .reset_in, .loop_current_ua_in, .loop_valid_in, .tick_1s_in,
        .motor_start_in, .motor_running_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scaled_value_out,
        .alarm_low_out, .alarm_high_out, .trip_low_out, .trip_high_out, .irq_out);
    // clock and a cycle ceiling well above the few hundred cycles needed
    initial begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end
    // ----
    // bus and process helpers
    // ----
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : wt
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_sys_in);
            while (tick_1s_in !== 1'b1) @(posedge clk_sys_in);
        end
    endtask : ticks
    task automatic setua(input current_t v);
        @(posedge clk_sys_in);
        level_ua <= v;
        wt(8);
    endtask : setua
    // address and data are offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rdw(input logic [7:0] a);
        @(posedge clk_sys_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rdw
    task automatic pulse_start;
        @(posedge clk_sys_in);
        start_req <= 1'b1;
        @(posedge clk_sys_in);
        start_req <= 1'b0;
    endtask : pulse_start
    task automatic conclude;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    // ----
    // main sequence
    // ----
    initial begin
        wt(8);
        reset_in <= 1'b0;
        wt(2);
        `chk({alarm_low_out, alarm_high_out, trip_low_out, trip_high_out, irq_out}, 5'h00)
        rdw(`APATS_OFS_SCALE);
        `chk(rd, `APATS_RST_SCALE)
        rdw(`APATS_OFS_TRIP_DLY);
        `chk(rd, `APATS_RST_DLY)
        rdw(`APATS_OFS_GRACE);
        `chk(rd, `APATS_RST_GRACE)
        foreach (rows[i]) begin
            setua(rows[i].ua);
            `chk(scaled_value_out, rows[i].sv)
        end
        $display("test reset and scaling done");
        wr(`APATS_OFS_ALM_LO, 32'h190);
        wr(`APATS_OFS_ALM_DLY, 32'h0000_0002);
        // start on a tick so no second is counted inside the settling wait
        ticks(1);
        setua(15'h0fa0);
        ticks(1);
        wt(3);
        `chk(alarm_low_out, 1'b0)
        setua(15'h2ee0);
        setua(15'h0fa0);
        ticks(1);
        wt(3);
        `chk(alarm_low_out, 1'b0)
        ticks(1);
        wt(3);
        `chk(alarm_low_out, 1'b1)
        setua(15'h2ee0);
        `chk(alarm_low_out, 1'b0)
        wr(`APATS_OFS_ALM_HI, 32'h258);
        wr(`APATS_OFS_ALM_DLY, 32'h0002_0002);
        setua(15'h4e20);
        ticks(1);
        wt(3);
        `chk(alarm_high_out, 1'b0)
        ticks(1);
        wt(3);
        `chk(alarm_high_out, 1'b1)
        $display("test alarms done");
        wr(`APATS_OFS_GRACE, 32'h0000_05ff);
        wr(`APATS_OFS_TRIP_LO, 32'h12c);
        wr(`APATS_OFS_TRIP_DLY, 32'h0000_0001);
        wr(`APATS_OFS_IRQ_MASK, 32'h4);
        setua(15'h0fa0);
        ticks(1);
        wt(5);
        `chk(trip_low_out, 1'b1)
        `chk(irq_out, 1'b1)
        setua(15'h2ee0);
        `chk(trip_low_out, 1'b1)
        wr(`APATS_OFS_CTRL, 32'h1);
        wr(`APATS_OFS_IRQ_STAT, 32'hf);
        wt(2);
        `chk({trip_low_out, irq_out}, 2'b00)
        $display("test low trip done");
        wr(`APATS_OFS_GRACE, 32'h0000_ff00);
        setua(15'h0fa0);
        ticks(2);
        wt(3);
        `chk(trip_low_out, 1'b0)
        pulse_start();
        wt(4);
        `chk(trip_low_out, 1'b1)
        stop_req <= 1'b1;
        setua(15'h2ee0);
        stop_req <= 1'b0;
        wr(`APATS_OFS_CTRL, 32'h1);
        wr(`APATS_OFS_TRIP_LO, 32'h0);
        wr(`APATS_OFS_TRIP_HI, 32'h320);
        wr(`APATS_OFS_TRIP_DLY, 32'h0001_0001);
        wr(`APATS_OFS_GRACE, 32'h0000_02ff);
        setua(15'h4e20);
        pulse_start();
        ticks(1);
        wt(3);
        `chk(trip_high_out, 1'b0)
        ticks(1);
        wt(3);
        `chk(trip_high_out, 1'b1)
        $display("test start grace done");
        wr(`APATS_OFS_STATUS, 32'h0);
        `chk(resp, `APATS_RESP_SLVERR)
        wr(8'h30, 32'h1);
        `chk(resp, `APATS_RESP_SLVERR)
        rdw(8'h30);
        `chk(rd, 32'h0)
        `chk(resp, `APATS_RESP_SLVERR)
        $display("test refused access done");
        conclude();
    end
endmodule : analog_process_alarm_trip_supervisor_bench
